// File: rtl/gfm_fault_monitor.sv
// Fault flags, response kind and fault injection of the rate sensor
`timescale 1ns/1ps
`default_nettype none
`include "gfm_params.svh"
module gfm_fault_monitor #(
	parameter int NVM_BYTES = 16,
	parameter logic [NVM_BYTES-1:0] NVM_SKIP = `GFM_NVM_SKIP,
	parameter int NVM_CYC = `GFM_NVM_NS / `GFM_CLK_NS,
	parameter int INJ_CYC = `GFM_INJ_NS / `GFM_CLK_NS
)(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Pins from outside the clock domain
	input wire logic csPinN,
	input wire logic pllUnlockPin,
	input wire logic regHighPin,
	input wire logic regLowPin,
	input wire logic ampLowPin,
	// Decoded command from the serial port logic
	input wire logic cmdValid,
	input wire logic cmdSensor,
	input wire logic cmdRead,
	input wire logic [8:0] cmdAddr,
	input wire logic cmdInject,
	// Measurements on the same clock
	input wire logic [15:0] rateData,
	input wire logic [15:0] quadValue,
	input wire logic [15:0] quadAccum,
	input wire logic [15:0] selfTestDev,
	input wire logic [NVM_BYTES*8-1:0] nvmImage,
	input wire logic [7:0] nvmStoredSum,
	// Response towards the serial port logic
	output logic respValid,
	output logic [1:0] respKind,
	output logic [15:0] respData,
	output logic [7:0] respFlags
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	if (NVM_CYC < 2 || NVM_CYC >= 65536 || INJ_CYC < 2 || INJ_CYC >= 16777216 || NVM_BYTES > 16) begin : g_bad
		$error("gfm_fault_monitor: parameter out of range");
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [4:0] syncA_q;
	logic [4:0] syncB_q;
	logic csPrev_q;
	logic csN;
	logic csFall;

	// Two flops per pin; chip select idles high
	always_ff @(posedge mclk) begin
		if (rst) begin
			syncA_q <= 5'h01;
			syncB_q <= 5'h01;
			csPrev_q <= 1'b1;
		end else begin
			syncA_q <= {ampLowPin, regLowPin, regHighPin, pllUnlockPin, csPinN};
			syncB_q <= syncA_q;
			csPrev_q <= syncB_q[0];
		end
	end

	assign csN = syncB_q[0];
	assign csFall = csPrev_q & ~csN;

	// ----------------------------------------
	// Detectors
	// ----------------------------------------
	function automatic logic [15:0] absVal(input logic [15:0] v);
		absVal = v[15] ? 16'(~v + 16'h0001) : v;
	endfunction

	logic [4:0] ovCnt_q, ovCnt_d, uvCnt_q, uvCnt_d;
	logic [15:0] nvmCnt_q, nvmCnt_d;
	logic [7:0] volCnt_q, volCnt_d;
	logic [7:0] volReg_q;
	logic nvmBad_q, nvmBad_d, porBad_q, porBad_d;
	logic [7:0] nvmSum;
	logic ovCond, uvCond, quadHi, accHi, selfLow, selfHigh;

	// Filters, checksum and volatile check timers
	always_comb begin
		nvmSum = 8'h00;
		for (int i = 0; i < NVM_BYTES; i++) begin
			if (!NVM_SKIP[i]) begin
				nvmSum = nvmSum ^ nvmImage[i*8 +: 8];
			end
		end
		// A glitch shorter than the filter never reaches the limit
		ovCnt_d = !syncB_q[2] ? 5'h00 : (ovCond ? ovCnt_q : 5'(ovCnt_q + 5'h01));
		uvCnt_d = !syncB_q[3] ? 5'h00 : (uvCond ? uvCnt_q : 5'(uvCnt_q + 5'h01));
		nvmCnt_d = (nvmCnt_q == 16'(NVM_CYC - 1)) ? 16'h0000 : 16'(nvmCnt_q + 16'h0001);
		nvmBad_d = nvmBad_q;
		if (nvmCnt_q == 16'(NVM_CYC - 1)) begin
			nvmBad_d = (nvmSum != nvmStoredSum);
		end
		volCnt_d = (volCnt_q == 8'(`GFM_VOL_CYC - 1)) ? 8'h00 : 8'(volCnt_q + 8'h01);
		porBad_d = porBad_q;
		if (volCnt_q == 8'(`GFM_VOL_CYC - 1)) begin
			porBad_d = (volReg_q != `GFM_VOL_ROM);
		end
	end

	// Volatile copy is written only by reset, standing in for power-up
	always_ff @(posedge mclk) begin
		if (rst) begin
			ovCnt_q <= 5'h00;
			uvCnt_q <= 5'h00;
			nvmCnt_q <= 16'h0000;
			volCnt_q <= 8'h00;
			volReg_q <= `GFM_VOL_ROM;
			nvmBad_q <= 1'b0;
			porBad_q <= 1'b0;
		end else begin
			ovCnt_q <= ovCnt_d;
			uvCnt_q <= uvCnt_d;
			nvmCnt_q <= nvmCnt_d;
			volCnt_q <= volCnt_d;
			nvmBad_q <= nvmBad_d;
			porBad_q <= porBad_d;
		end
	end

	assign ovCond = (ovCnt_q == `GFM_FILT_CYC);
	assign uvCond = (uvCnt_q == `GFM_FILT_CYC);
	assign quadHi = absVal(quadValue) > `GFM_QUAD_LIMIT;
	assign accHi = absVal(quadAccum) >= `GFM_QACC_LIMIT;
	assign selfLow = absVal(selfTestDev) > `GFM_SELF_LOW;
	assign selfHigh = absVal(selfTestDev) > `GFM_SELF_HIGH;

	// ----------------------------------------
	// Fault injection sequencer
	// ----------------------------------------
	gfm_pkg::gfm_inj_e inj_q, inj_d;
	logic [23:0] injCnt_q, injCnt_d;
	logic injReq_q, injReq_d;
	logic postInj_q, postInj_d;
	logic inject;
	logic [15:0] fault_q, fault_d;

	// Inject bit is taken at command end, so its effect is seen from the next capture on
	always_comb begin
		injReq_d = injReq_q;
		if (cmdValid && cmdSensor) begin
			injReq_d = cmdInject;
		end
		inj_d = inj_q;
		injCnt_d = injCnt_q;
		postInj_d = postInj_q;
		if (postInj_q && !fault_q[`GFM_FB_SELF]) begin
			postInj_d = 1'b0;
		end
		case (inj_q)
			gfm_pkg::INJ_IDLE: begin
				if (injReq_q) begin
					inj_d = gfm_pkg::INJ_ACTIVE;
				end
			end
			gfm_pkg::INJ_ACTIVE: begin
				if (!injReq_q) begin
					inj_d = gfm_pkg::INJ_DECAY;
					injCnt_d = 24'h000000;
					postInj_d = 1'b1;
				end
			end
			gfm_pkg::INJ_DECAY: begin
				injCnt_d = 24'(injCnt_q + 24'h000001);
				if (injReq_q) begin
					inj_d = gfm_pkg::INJ_ACTIVE;
				end else if (injCnt_q == 24'(INJ_CYC - 1)) begin
					inj_d = gfm_pkg::INJ_IDLE;
				end
			end
			default: begin
				inj_d = gfm_pkg::INJ_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			inj_q <= gfm_pkg::INJ_IDLE;
			injCnt_q <= 24'h000000;
			injReq_q <= 1'b0;
			postInj_q <= 1'b0;
		end else begin
			inj_q <= inj_d;
			injCnt_q <= injCnt_d;
			injReq_q <= injReq_d;
			postInj_q <= postInj_d;
		end
	end

	// Injected conditions hold through the decay window
	assign inject = (inj_q != gfm_pkg::INJ_IDLE);

	// ----------------------------------------
	// Flags, capture and response
	// ----------------------------------------
	logic [15:0] cond;
	logic errForce, faultRd;
	logic [1:0] kindNow;
	logic [7:0] sensorView;
	logic [1:0] snapKind_q, snapKind_d;
	logic [7:0] snapFlags_q, snapFlags_d;
	logic [15:0] snapRate_q, snapRate_d;
	logic respValid_d;
	logic [1:0] respKind_d;
	logic [15:0] respData_d;
	logic [7:0] respFlags_d;

	// Built from sources, not from cond, to avoid a loop; a fault read ends the post-inject error
	assign errForce = syncB_q[1] | inject | selfHigh | (postInj_q & fault_q[`GFM_FB_SELF] & ~faultRd);
	assign faultRd = cmdValid & cmdRead & ~cmdSensor & (cmdAddr == `GFM_FAULT_ADDR);
	assign sensorView = fault_q[7:0] | {5'h00, fault_q[`GFM_FB_AMP], 2'h0};

	// Raw conditions and the sticky update; setting beats clearing
	always_comb begin
		cond = 16'h0000;
		cond[`GFM_FB_PLL] = syncB_q[1] | inject;
		cond[`GFM_FB_Q] = quadHi | accHi | inject;
		cond[`GFM_FB_NVM] = nvmBad_q | inject;
		cond[`GFM_FB_POR] = porBad_q | inject;
		cond[`GFM_FB_OV] = ovCond | inject;
		cond[`GFM_FB_UV] = uvCond | inject;
		cond[`GFM_FB_PWR] = cond[`GFM_FB_OV] | cond[`GFM_FB_UV];
		cond[`GFM_FB_AMP] = syncB_q[4] | inject;
		cond[`GFM_FB_SELF] = selfLow | inject;
		cond[`GFM_FB_INJ] = (inj_q == gfm_pkg::INJ_ACTIVE);
		cond[`GFM_FB_FAIL] = errForce | inject;
		// Reply below takes fault_q first, so the clear loses nothing
		fault_d = ((fault_q & ~{16{faultRd}}) | cond) & `GFM_FLAG_MASK;
		if (inj_q == gfm_pkg::INJ_ACTIVE) begin
			kindNow = gfm_pkg::KIND_SELF;
		end else if (errForce) begin
			kindNow = gfm_pkg::KIND_ERR;
		end else begin
			kindNow = gfm_pkg::KIND_RATE;
		end
		snapKind_d = snapKind_q;
		snapFlags_d = snapFlags_q;
		snapRate_d = snapRate_q;
		if (csFall) begin
			snapKind_d = kindNow;
			snapFlags_d = sensorView;
			snapRate_d = rateData;
		end
		respValid_d = 1'b0;
		respKind_d = respKind;
		respData_d = respData;
		respFlags_d = respFlags;
		if (cmdValid && cmdSensor) begin
			respValid_d = 1'b1;
			respKind_d = snapKind_q;
			respData_d = snapRate_q;
			respFlags_d = snapFlags_q;
		end else if (faultRd) begin
			respValid_d = 1'b1;
			respKind_d = gfm_pkg::KIND_REG;
			respData_d = fault_q;
			respFlags_d = 8'h00;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			fault_q <= 16'h0000;
			snapKind_q <= gfm_pkg::KIND_RATE;
			snapFlags_q <= 8'h00;
			snapRate_q <= 16'h0000;
			respValid <= 1'b0;
			respKind <= gfm_pkg::KIND_RATE;
			respData <= 16'h0000;
			respFlags <= 8'h00;
		end else begin
			fault_q <= fault_d;
			snapKind_q <= snapKind_d;
			snapFlags_q <= snapFlags_d;
			snapRate_q <= snapRate_d;
			respValid <= respValid_d;
			respKind <= respKind_d;
			respData <= respData_d;
			respFlags <= respFlags_d;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sticky_hold_a: assert property (fault_q[`GFM_FB_NVM] && !faultRd |=> fault_q[`GFM_FB_NVM])
		else $error("flag dropped without a fault read");
	reassert_a: assert property (faultRd && cond[`GFM_FB_Q] |=> fault_q[`GFM_FB_Q])
		else $error("persistent fault not reasserted");
	fault_read_a: assert property (faultRd |=> respValid && respKind == 2'h3 && respData == $past(fault_q))
		else $error("fault read reply wrong");
	pll_kind_a: assert property (csFall && syncB_q[1] && inj_q != gfm_pkg::INJ_ACTIVE |=> snapKind_q == 2'h0)
		else $error("loop lock loss not reported as error");
	quad_flag_a: assert property (quadHi |=> fault_q[`GFM_FB_Q])
		else $error("quadrature flag missing");
	supply_pair_a: assert property ($rose(fault_q[`GFM_FB_OV]) |-> fault_q[`GFM_FB_PWR])
		else $error("supply flag not set with high flag");
	glitch_filt_a: assert property (!syncB_q[2] |=> !ovCond ##1 !ovCond)
		else $error("regulator glitch passed filter");
	gross_fail_a: assert property (errForce |=> fault_q[`GFM_FB_FAIL])
		else $error("gross error flag missing");
	inject_kind_a: assert property (inj_q == gfm_pkg::INJ_ACTIVE && csFall |=> snapKind_q == 2'h2)
		else $error("inject not reported as self-test");
	amp_merge_a: assert property (csFall && fault_q[`GFM_FB_AMP] |=> snapFlags_q[`GFM_FB_SELF])
		else $error("amplitude flag not merged");

	sensor_resp_c: cover property (cmdValid && cmdSensor ##1 respValid);
	fault_clear_c: cover property (faultRd ##1 fault_q == 16'h0000);
	inject_seq_c: cover property (inj_q == gfm_pkg::INJ_ACTIVE ##1 inj_q == gfm_pkg::INJ_DECAY);
endmodule
`default_nettype wire

// File: rtl/gfm_params.svh
// Constants of the gyro fault monitor: offsets, bit positions, limits, timing
`ifndef GFM_PARAMS_SVH
`define GFM_PARAMS_SVH
`define GFM_FAULT_ADDR 9'h00a
`define GFM_FB_FAIL 11
`define GFM_FB_AMP 10
`define GFM_FB_OV 9
`define GFM_FB_UV 8
`define GFM_FB_PLL 7
`define GFM_FB_Q 6
`define GFM_FB_NVM 5
`define GFM_FB_POR 4
`define GFM_FB_PWR 3
`define GFM_FB_SELF 2
`define GFM_FB_INJ 1
`define GFM_FLAG_MASK 16'h0ffe
`define GFM_QUAD_LIMIT 16'h1000
`define GFM_QACC_LIMIT 16'h0140
`define GFM_SELF_LOW 16'h0200
`define GFM_SELF_HIGH 16'h0740
`define GFM_VOL_ROM 8'ha5
`define GFM_NVM_SKIP 16'hc000
`define GFM_CLK_NS 4
`define GFM_NVM_NS 50000
`define GFM_VOL_NS 1000
`define GFM_INJ_NS 50000000
`define GFM_VOL_CYC (`GFM_VOL_NS / `GFM_CLK_NS)
`define GFM_FILT_CYC 5'h10
`endif

// File: rtl/gfm_pkg.sv
// Types of the gyro fault monitor
package gfm_pkg;
	typedef enum logic [1:0] {
		KIND_ERR = 2'h0,
		KIND_RATE = 2'h1,
		KIND_SELF = 2'h2,
		KIND_REG = 2'h3
	} gfm_kind_e;
	typedef enum logic [2:0] {
		INJ_IDLE = 3'h1,
		INJ_ACTIVE = 3'h2,
		INJ_DECAY = 3'h4
	} gfm_inj_e;
endpackage

// File: tb/gfm_master_model.sv
// Master side model: frames one exchange per call and keeps the reply
`timescale 1ns/1ps
`default_nettype none
module gfm_master_model (
	// Clock
	input wire logic mclk,
	// Command side
	output var logic csPinN,
	output var logic cmdValid,
	output var logic cmdSensor,
	output var logic cmdRead,
	output var logic [8:0] cmdAddr,
	output var logic cmdInject,
	// Reply side
	input wire logic respValid,
	input wire logic [1:0] respKind,
	input wire logic [15:0] respData,
	input wire logic [7:0] respFlags
);
	logic gotValid;
	logic [1:0] gotKind;
	logic [15:0] gotData;
	logic [7:0] gotFlags;
	// Idle: deselected, no command
	initial begin
		csPinN = 1'b1;
		cmdValid = 1'b0;
		cmdSensor = 1'b0;
		cmdRead = 1'b0;
		cmdAddr = 9'h000;
		cmdInject = 1'b0;
	end
	// One exchange; the bench polls the fault bytes far faster than the scaled poll rate
	task automatic xfer(input logic sens, input logic [8:0] addr, input logic inj);
		@(posedge mclk);
		csPinN <= 1'b0;
		repeat (4) @(posedge mclk);
		cmdValid <= 1'b1;
		cmdSensor <= sens;
		cmdRead <= ~sens;
		cmdAddr <= addr;
		cmdInject <= inj; // Inject bit only on sensor requests
		@(posedge mclk);
		cmdValid <= 1'b0;
		#1;
		gotValid = respValid;
		gotKind = respKind;
		gotData = respData;
		gotFlags = respFlags;
		@(posedge mclk);
		csPinN <= 1'b1; // Deselect so the next frame starts with a fresh fall
		repeat (4) @(posedge mclk);
	endtask
endmodule
`default_nettype wire

// File: tb/gyro_fault_monitor_tb_top.sv
// Self-checking bench of the gyro fault monitor
`timescale 1ns/1ps
`default_nettype none
`define EXPECT(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module gyro_fault_monitor_tb_top;
	typedef struct packed {logic [3:0] p; logic [15:0] qv, qa, sd; logic [7:0] sum, b15; logic [15:0] ex;} gfm_case_s;
	logic mclk, rst, csPinN, cmdValid, cmdSensor, cmdRead, cmdInject, respValid;
	logic [3:0] pins;
	logic [8:0] cmdAddr;
	logic [15:0] quadValue, quadAccum, selfTestDev, respData;
	logic [127:0] nvmImage;
	logic [7:0] nvmStoredSum, respFlags;
	logic [1:0] respKind;
	int failures, compares;
	// Pins {amp, low, high, pll}, quad, accumulator, self-test, sum, trim byte, expected fault word
	gfm_case_s c [13] = '{
		'{4'h1, 16'h0, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0880}, '{4'h2, 16'h0, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0208},
		'{4'h4, 16'h0, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0108}, '{4'h8, 16'h0, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0400},
		'{4'h0, 16'h1000, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0}, '{4'h0, 16'h1001, 16'h0, 16'h0, 8'h0, 8'h0, 16'h0040},
		'{4'h0, 16'h0, 16'h013f, 16'h0, 8'h0, 8'h0, 16'h0}, '{4'h0, 16'h0, 16'h0140, 16'h0, 8'h0, 8'h0, 16'h0040},
		'{4'h0, 16'h0, 16'h0, 16'h0200, 8'h0, 8'h0, 16'h0}, '{4'h0, 16'h0, 16'h0, 16'h0201, 8'h0, 8'h0, 16'h0004},
		'{4'h0, 16'h0, 16'h0, 16'hf8bf, 8'h0, 8'h0, 16'h0804}, '{4'h0, 16'h0, 16'h0, 16'h0, 8'h01, 8'h0, 16'h0020},
		'{4'h0, 16'h0, 16'h0, 16'h0, 8'h0, 8'hff, 16'h0}};
	// ------------------------------------------------------------
	// Design and master model
	// ------------------------------------------------------------
	gfm_fault_monitor #(.NVM_CYC(8), .INJ_CYC(20)) gfm_fault_monitor_i (.mclk(mclk), .rst(rst), .csPinN(csPinN),
		.pllUnlockPin(pins[0]), .regHighPin(pins[1]), .regLowPin(pins[2]), .ampLowPin(pins[3]),
		.cmdValid(cmdValid), .cmdSensor(cmdSensor), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdInject(cmdInject),
		.rateData(16'h5dc0), .quadValue(quadValue), .quadAccum(quadAccum), .selfTestDev(selfTestDev),
		.nvmImage(nvmImage), .nvmStoredSum(nvmStoredSum), .respValid(respValid), .respKind(respKind),
		.respData(respData), .respFlags(respFlags));
	gfm_master_model gfm_master_model_i (.mclk(mclk), .csPinN(csPinN), .cmdValid(cmdValid),
		.cmdSensor(cmdSensor), .cmdRead(cmdRead), .cmdAddr(cmdAddr), .cmdInject(cmdInject), .respValid(respValid),
		.respKind(respKind), .respData(respData), .respFlags(respFlags));
	// Fault register read with its expected word
	task automatic rd(input logic [15:0] ex);
		gfm_master_model_i.xfer(1'b0, 9'h00a, 1'b0);
		`EXPECT("fvalid", 1'b1, gfm_master_model_i.gotValid)
		`EXPECT("fkind", 2'h3, gfm_master_model_i.gotKind)
		`EXPECT("fault", ex, gfm_master_model_i.gotData)
		`EXPECT("fflags", 8'h00, gfm_master_model_i.gotFlags)
	endtask
	// Sensor request with its expected kind
	task automatic sens(input logic inj, input logic [1:0] k);
		gfm_master_model_i.xfer(1'b1, 9'h000, inj);
		`EXPECT("svalid", 1'b1, gfm_master_model_i.gotValid)
		`EXPECT("skind", k, gfm_master_model_i.gotKind)
	endtask
	task automatic print_verdict();
		$display("Counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		repeat (100000) @(posedge mclk);
		failures++;
		print_verdict();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		pins = 4'h0;
		quadValue = 16'h0;
		quadAccum = 16'h0;
		selfTestDev = 16'h0;
		nvmImage = 128'h0;
		nvmStoredSum = 8'h0;
		failures = 0;
		compares = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		rd(16'h0000);
		sens(1'b0, 2'h1);
		`EXPECT("rate", 16'h5dc0, gfm_master_model_i.gotData)
		gfm_master_model_i.xfer(1'b0, 9'h008, 1'b0);
		`EXPECT("unmapped", 1'b0, gfm_master_model_i.gotValid)
		$display("reset and map test done");
		// Short regulator glitches must be filtered out
		for (int j = 1; j < 3; j++) begin
			pins <= 4'h1 << j;
			repeat (6) @(posedge mclk);
			pins <= 4'h0;
			repeat (40) @(posedge mclk);
			rd(16'h0000);
		end
		$display("glitch test done");
		for (int i = 0; i < 13; i++) begin
			pins <= c[i].p;
			quadValue <= c[i].qv;
			quadAccum <= c[i].qa;
			selfTestDev <= c[i].sd;
			nvmStoredSum <= c[i].sum;
			nvmImage <= {c[i].b15, 120'h0};
			repeat (40) @(posedge mclk);
			sens(1'b0, c[i].ex[11] ? 2'h0 : 2'h1);
			`EXPECT("sflags", c[i].ex[7:0] | {5'h0, c[i].ex[10], 2'h0}, gfm_master_model_i.gotFlags)
			rd(c[i].ex);
			rd(c[i].ex);
			pins <= 4'h0;
			quadValue <= 16'h0;
			quadAccum <= 16'h0;
			selfTestDev <= 16'h0;
			nvmStoredSum <= 8'h0;
			nvmImage <= 128'h0;
			repeat (40) @(posedge mclk);
			rd(c[i].ex);
			rd(16'h0000);
			$display("fault case %0d done", i);
		end
		// Injection: late by one exchange, then decay, error kind until a fault read, then back to normal
		sens(1'b1, 2'h1);
		sens(1'b1, 2'h2);
		repeat (60) @(posedge mclk);
		rd(16'h0ffe);
		sens(1'b0, 2'h2);
		repeat (60) @(posedge mclk);
		sens(1'b0, 2'h0);
		rd(16'h0ffe);
		rd(16'h0000);
		sens(1'b0, 2'h1);
		$display("injection test done");
		print_verdict();
	end
endmodule
`default_nettype wire
